// file: common/slice_instr_pkg.sv
`default_nettype none
package slice_instr_pkg;
  // word widths per slice generation
  localparam int W_GEN_ONE   = 15;
  localparam int W_GEN_TWO   = 20;
  localparam int W_GEN_THREE = 22;
  localparam int W_MAX       = 22;

  typedef enum logic [1:0] {
    GEN_ONE   = 2'h0,
    GEN_TWO   = 2'h1,
    GEN_THREE = 2'h2
  } gen_t;

  // preset operations
  localparam logic [3:0] OP_C_PROD    = 4'h0;
  localparam logic [3:0] OP_CASC_PROD = 4'h1;
  localparam logic [3:0] OP_RES_PROD  = 4'h2;
  localparam logic [3:0] OP_PROD      = 4'h3;
  localparam logic [3:0] OP_C_CAT     = 4'h4;
  localparam logic [3:0] OP_C_M_CAT   = 4'h5;
  localparam logic [3:0] OP_C         = 4'h6;
  localparam logic [3:0] OP_CUSTOM    = 4'h7;

  // xy source, word bits 3:0
  localparam logic [3:0] XY_ZERO     = 4'h0;
  localparam logic [3:0] XY_RES      = 4'h2;
  localparam logic [3:0] XY_CAT      = 4'h3;
  localparam logic [3:0] XY_PROD     = 4'h5;
  localparam logic [3:0] XY_C        = 4'hC;
  localparam logic [3:0] XY_RES_C    = 4'hE;
  localparam logic [3:0] XY_CAT_C    = 4'hF;
  // z source, word bits 6:4
  localparam logic [2:0] Z_ZERO      = 3'h0;
  localparam logic [2:0] Z_CASC      = 3'h1;
  localparam logic [2:0] Z_RES       = 3'h2;
  localparam logic [2:0] Z_C         = 3'h3;
  localparam logic [2:0] Z_CASC_SHR  = 3'h5;
  localparam logic [2:0] Z_RES_SHR   = 3'h6;
  localparam int Z_SHIFT = 17;
  // arithmetic unit function, word bits 10:7
  localparam logic [3:0] ALU_ADD     = 4'h0;
  localparam logic [3:0] ALU_SUB     = 4'h3;
  // carry source, word bits 14:12; code 0 takes bit 11
  localparam logic [2:0] CY_BIT      = 3'h0;
  localparam logic [2:0] CY_CASC_INF = 3'h1;
  localparam logic [2:0] CY_CASC_ZER = 3'h2;
  localparam logic [2:0] CY_RES_INF  = 3'h3;
  localparam logic [2:0] CY_RES_ZER  = 3'h4;
  localparam logic [2:0] CY_WIDE_PAR = 3'h5;
  localparam logic [2:0] CY_WIDE_SEQ = 3'h6;
  localparam logic [2:0] CY_PROD_RND = 3'h7;
  // w source, word bits 21:20
  localparam logic [1:0] W_ZERO = 2'h0;
  localparam logic [1:0] W_RES  = 2'h1;
  localparam logic [1:0] W_RND  = 2'h2;
  localparam logic [1:0] W_C    = 2'h3;

  // field positions
  localparam int XY_LSB = 0;
  localparam int Z_LSB  = 4;
  localparam int ALU_LSB = 7;
  localparam int CIN_BIT = 11;
  localparam int CY_LSB = 12;
  localparam int IN_LSB = 15;
  localparam int W_LSB  = 20;

  // register offsets and reset values
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_CUSTOM = 8'h04;
  localparam logic [7:0] OFS_STAGE  = 8'h08;
  localparam logic [7:0] OFS_WORD   = 8'h0C;
  localparam logic [31:0] RST_CTRL   = 32'h0000_0000;
  localparam logic [31:0] RST_CUSTOM = 32'h0000_0000;
  localparam logic [31:0] RST_STAGE  = 32'h0000_0000;

  typedef struct packed {
    logic       mult_negate;
    logic       mult_b_ad;
    logic       mult_a_ad;
    logic       preadd_in_b;
  } static_t;

  typedef struct packed {
    gen_t       gen;
    logic [3:0] preset;
    logic       cin_port_sel;
    logic       cin_value;
    logic [3:0] xy;
    logic [2:0] z;
    logic [3:0] alu;
    logic [2:0] carry_sel;
    logic [1:0] w;
    logic [3:0] preadd_mode;
    logic       a_stage_one;
    logic       b_stage_one;
    static_t    stat;
  } cfg_t;
endpackage
`default_nettype wire

// file: hdl/instr_cfg_regs.sv
`timescale 1ns/1ps
`default_nettype none
module instr_cfg_regs (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [7:0]                    paddr,
  input  wire logic [31:0]                   pwdata,
  input  wire logic [slice_instr_pkg::W_MAX-1:0] word,
  output logic      [31:0]                   prdata,
  output logic                               pslverr,
  output slice_instr_pkg::cfg_t              cfg
);
  logic [31:0] ctrl_q, ctrl_d, cust_q, cust_d, stage_q, stage_d;
  logic        hit;
  logic        wr;

  always_comb begin
    hit = (paddr == slice_instr_pkg::OFS_CTRL) || (paddr == slice_instr_pkg::OFS_CUSTOM)
       || (paddr == slice_instr_pkg::OFS_STAGE) || (paddr == slice_instr_pkg::OFS_WORD);
    wr      = psel && penable && pwrite;
    ctrl_d  = ctrl_q;
    cust_d  = cust_q;
    stage_d = stage_q;
    if (wr && paddr == slice_instr_pkg::OFS_CTRL) ctrl_d = pwdata & 32'h0000_03F3;
    if (wr && paddr == slice_instr_pkg::OFS_CUSTOM) cust_d = pwdata & 32'h0003_77FF;
    if (wr && paddr == slice_instr_pkg::OFS_STAGE) stage_d = pwdata & 32'h0000_03FF;
    pslverr = psel && penable && !hit;
    case (paddr)
      slice_instr_pkg::OFS_CTRL:   prdata = ctrl_q;
      slice_instr_pkg::OFS_CUSTOM: prdata = cust_q;
      slice_instr_pkg::OFS_STAGE:  prdata = stage_q;
      slice_instr_pkg::OFS_WORD:   prdata = {10'h000, word};
      default:                     prdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q  <= slice_instr_pkg::RST_CTRL;
      cust_q  <= slice_instr_pkg::RST_CUSTOM;
      stage_q <= slice_instr_pkg::RST_STAGE;
    end else begin
      ctrl_q  <= ctrl_d;
      cust_q  <= cust_d;
      stage_q <= stage_d;
    end
  end

  always_comb begin
    cfg.gen          = (ctrl_q[1:0] == 2'h3) ? slice_instr_pkg::GEN_THREE
                                               : slice_instr_pkg::gen_t'(ctrl_q[1:0]);
    cfg.preset       = ctrl_q[7:4];
    cfg.cin_port_sel = ctrl_q[8];
    cfg.cin_value    = ctrl_q[9];
    cfg.xy           = cust_q[3:0];
    cfg.z            = cust_q[6:4];
    cfg.alu          = cust_q[10:7];
    cfg.carry_sel    = cust_q[14:12];
    cfg.w            = cust_q[17:16];
    cfg.preadd_mode  = stage_q[3:0];
    cfg.a_stage_one  = stage_q[4];
    cfg.b_stage_one  = stage_q[5];
    cfg.stat         = slice_instr_pkg::static_t'(stage_q[9:6]);
  end
endmodule // instr_cfg_regs
`default_nettype wire

// file: hdl/slice_instr_const.sv
// Notes on behaviour
// (RULE1) word is 15, 20 or 22 bits
// (RULE2) word holds select, carry, alu, input-stage bits
// (RULE3) bits 3:0 pick the xy source
// (RULE4) bits 6:4 pick the z source
// (RULE5) bits 14:12 pick the carry source
// (RULE6) external carry port lands at bit 11
// (RULE7) third generation carries w source select
// (RULE8) third generation pre-adder picks a or b
// (RULE9) third generation multiplier a-source select
// (RULE10) third generation multiplier b-source select
// (RULE11) a stage (gen three), b stage (gens two, three)
// (RULE12) seven presets; custom fields only when custom
// (RULE13) newest variant may negate the product
// (RULE14) controller muxes several words per step
// (RULE15) word constant, no latency or clock dependence
//
// The address map and register access over APB were decided locally.
`timescale 1ns/1ps
`default_nettype none
module slice_instr_const (
  input  wire logic                               pclk,
  input  wire logic                               presetn,
  input  wire logic                               psel,
  input  wire logic                               penable,
  input  wire logic                               pwrite,
  input  wire logic [7:0]                         paddr,
  input  wire logic [31:0]                        pwdata,
  output logic      [31:0]                        prdata,
  output logic                                    pready,
  output logic                                    pslverr,
  input  wire logic                               carry_in,
  output logic      [slice_instr_pkg::W_MAX-1:0]  instr_word,
  output logic      [4:0]                         word_width,
  output slice_instr_pkg::static_t                static_ctrl
);
  ////////////////////////////////////////////////////////////////////////////
  slice_instr_pkg::cfg_t cfg;

  instr_cfg_regs u_regs (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .word    (instr_word),
    .prdata  (prdata),
    .pslverr (pslverr),
    .cfg     (cfg)
  );

  assign pready = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // input-stage control: {b_stage_one, sub, d_en, zero_a, a_stage_one}
  function automatic logic [4:0] preadd_code(input logic [3:0] mode);
    case (mode)
      4'h0:    preadd_code = 5'h02;
      4'h1:    preadd_code = 5'h00;
      4'h2:    preadd_code = 5'h01;
      4'h3:    preadd_code = 5'h04;
      4'h4:    preadd_code = 5'h05;
      4'h5:    preadd_code = 5'h06;
      4'h6:    preadd_code = 5'h08;
      4'h7:    preadd_code = 5'h09;
      4'h8:    preadd_code = 5'h0C;
      4'h9:    preadd_code = 5'h0D;
      default: preadd_code = 5'h00;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic [3:0] xy;
  logic [2:0] z;
  logic [3:0] alu;
  logic [2:0] cy;
  logic [1:0] w;
  logic       cin_bit;
  logic [4:0] inmode;

  always_comb begin
    xy  = slice_instr_pkg::XY_PROD;
    z   = slice_instr_pkg::Z_C;
    alu = slice_instr_pkg::ALU_ADD;
    cy  = slice_instr_pkg::CY_BIT;
    w   = slice_instr_pkg::W_ZERO;
    case (cfg.preset)
      slice_instr_pkg::OP_C_PROD: begin // RULE12
        z = slice_instr_pkg::Z_C;
      end
      slice_instr_pkg::OP_CASC_PROD: begin
        z = slice_instr_pkg::Z_CASC;
      end
      slice_instr_pkg::OP_RES_PROD: begin
        z = slice_instr_pkg::Z_RES;
      end
      slice_instr_pkg::OP_PROD: begin
        z = slice_instr_pkg::Z_ZERO;
      end
      slice_instr_pkg::OP_C_CAT: begin
        xy = slice_instr_pkg::XY_CAT;
      end
      slice_instr_pkg::OP_C_M_CAT: begin
        xy  = slice_instr_pkg::XY_CAT;
        alu = slice_instr_pkg::ALU_SUB;
      end
      slice_instr_pkg::OP_C: begin
        xy = slice_instr_pkg::XY_ZERO;
      end
      slice_instr_pkg::OP_CUSTOM: begin // RULE12
        xy  = cfg.xy;
        z   = cfg.z;
        alu = cfg.alu;
        cy  = cfg.carry_sel;
        w   = cfg.w;
      end
      default: begin
        xy = slice_instr_pkg::XY_PROD;
      end
    endcase
    // carry bit is the live port when selected, else the stored constant
    cin_bit = cfg.cin_port_sel ? carry_in : cfg.cin_value; // RULE6 RULE15
    inmode  = preadd_code(cfg.preadd_mode);
    inmode[4] = cfg.b_stage_one; // RULE11
    if (cfg.gen == slice_instr_pkg::GEN_THREE) begin
      inmode[0] = cfg.a_stage_one; // RULE11
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    instr_word = '0;
    instr_word[slice_instr_pkg::XY_LSB +: 4]  = xy; // RULE3
    instr_word[slice_instr_pkg::Z_LSB +: 3]   = z; // RULE4
    instr_word[slice_instr_pkg::ALU_LSB +: 4] = alu; // RULE2
    instr_word[slice_instr_pkg::CIN_BIT]      = cin_bit; // RULE6
    instr_word[slice_instr_pkg::CY_LSB +: 3]  = cy; // RULE5
    static_ctrl = '0;
    word_width  = 5'(slice_instr_pkg::W_GEN_ONE); // RULE1
    case (cfg.gen)
      slice_instr_pkg::GEN_TWO: begin
        instr_word[slice_instr_pkg::IN_LSB +: 5] = inmode; // RULE2
        word_width = 5'(slice_instr_pkg::W_GEN_TWO); // RULE1
      end
      slice_instr_pkg::GEN_THREE: begin
        instr_word[slice_instr_pkg::IN_LSB +: 5] = inmode;
        instr_word[slice_instr_pkg::W_LSB +: 2]  = w; // RULE7
        word_width  = 5'(slice_instr_pkg::W_GEN_THREE); // RULE1
        static_ctrl = cfg.stat; // RULE8 RULE9 RULE10 RULE13
      end
      default: begin
        word_width = 5'(slice_instr_pkg::W_GEN_ONE);
      end
    endcase
  end
endmodule // slice_instr_const
`default_nettype wire

// file: sim/slice_instr_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module slice_instr_monitor (
  input wire logic                              pclk,
  input wire logic                              presetn,
  input wire logic                              psel,
  input wire logic                              penable,
  input wire logic                              pwrite,
  input wire logic [7:0]                        paddr,
  input wire logic [31:0]                       prdata,
  input wire logic                              pready,
  input wire logic                              pslverr,
  input wire logic                              carry_in,
  input wire logic [slice_instr_pkg::W_MAX-1:0] instr_word,
  input wire logic [4:0]                        word_width,
  input wire slice_instr_pkg::static_t          static_ctrl
);
  logic acc;
  logic bus_wr;
  assign acc    = psel && penable;
  assign bus_wr = acc && pwrite;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_width_legal: assert property (word_width inside {5'h0F, 5'h14, 5'h16})
    else $error("illegal word width");
  chk_gen1_top: assert property (word_width == 5'h0F |-> instr_word[21:15] == 7'h00)
    else $error("bits above 15-bit word set");
  chk_gen2_top: assert property (word_width == 5'h14 |-> instr_word[21:20] == 2'h0)
    else $error("w field outside third generation");
  chk_static_gen: assert property (word_width != 5'h16 |-> static_ctrl == 4'h0)
    else $error("static selects outside third generation");
  chk_word_hold: assert property (!bus_wr ##1 $stable(carry_in) |-> $stable(instr_word))
    else $error("word moved without cause");
  chk_carry_follow: assert property (!bus_wr ##1 $changed(instr_word[11]) |-> instr_word[11] == carry_in)
    else $error("bit 11 does not follow carry input");
  chk_no_wait: assert property (acc |-> pready)
    else $error("wait state inserted");
  chk_err_decode: assert property (acc |-> pslverr == (paddr > 8'h0C || paddr[1:0] != 2'h0))
    else $error("error response wrong");
  chk_word_read: assert property (acc && !pwrite && paddr == 8'h0C |-> prdata == {10'h000, instr_word})
    else $error("word readback differs");
  cover property (word_width == 5'h16 && static_ctrl != 4'h0);
  cover property (acc && pslverr);
  cover property (acc && pwrite && paddr == 8'h0C);
endmodule // slice_instr_monitor
bind slice_instr_const slice_instr_monitor slice_instr_monitor_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .carry_in(carry_in), .instr_word(instr_word), .word_width(word_width), .static_ctrl(static_ctrl));
`default_nettype wire

// file: sim/instr_step_mux.sv
`timescale 1ns/1ps
`default_nettype none
module instr_step_mux (
  input  wire logic        pclk,
  input  wire logic        load,
  input  wire logic [1:0]  slot,
  input  wire logic [21:0] word,
  output logic      [21:0] step_word
);
  logic [21:0] mem_q [4];
  // slot picks the stored word for the current step
  always_ff @(posedge pclk) if (load) mem_q[slot] <= word;
  assign step_word = mem_q[slot];
endmodule // instr_step_mux
`default_nettype wire

// file: sim/test_slice_instr_const.sv
`timescale 1ns/1ps
`default_nettype none
module test_slice_instr_const;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, carry_in, load, err;
  logic [7:0]  paddr;
  logic [1:0]  slot;
  logic [4:0]  word_width, ewd;
  logic [31:0] pwdata, prdata, lf, rd, cv, uv, sv;
  logic [21:0] instr_word, step_word, ew, em;
  logic [3:0]  pac [16] = '{4'h2, 4'h0, 4'h1, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9,
                            4'hC, 4'hD, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0};
  slice_instr_pkg::static_t static_ctrl, es;
  int          failures, cmp_count;
  logic [21:0] q [$];
  slice_instr_const slice_instr_const_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .carry_in(carry_in), .instr_word(instr_word), .word_width(word_width), .static_ctrl(static_ctrl));
  instr_step_mux instr_step_mux_inst (.pclk(pclk), .load(load), .slot(slot), .word(instr_word), .step_word(step_word));
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("comparisons=%0d mismatches=%0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic cmp_word(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cmp_rd(input logic [31:0] g, input logic [31:0] e);
    cmp_word(g, e);
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // reference word from the field rules
  task automatic model(input logic ci);
    logic [3:0] xy, al;
    logic [2:0] z, cy;
    logic [1:0] w;
    {xy, z, al, cy, w} = {4'h5, 3'h3, 4'h0, 3'h0, 2'h0};
    case (cv[7:4])
      4'h1: z = 3'h1;
      4'h2: z = 3'h2;
      4'h3: z = 3'h0;
      4'h4: xy = 4'h3;
      4'h5: {xy, al} = {4'h3, 4'h3};
      4'h6: xy = 4'h0;
      4'h7: {xy, z, al, cy, w} = {uv[3:0], uv[6:4], uv[10:7], uv[14:12], uv[17:16]};
      default: ;
    endcase
    ew = {w, sv[5], pac[sv[3:0]], cy, cv[8] ? ci : cv[9], al, z, xy};
    if (cv[1])
      ew[15] = sv[4];
    ew = ew & (cv[1] ? 22'h3FFFFF : cv[0] ? 22'h0FFFFF : 22'h007FFF);
    em = (cy != 3'h0) ? 22'h3FF7FF : 22'h3FFFFF;
    ewd = cv[1] ? 5'h16 : cv[0] ? 5'h14 : 5'h0F;
    es = cv[1] ? sv[9:6] : 4'h0;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    // request stands until ready is seen; a hang is left to the watchdog
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    {rd, err} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
  endtask
  task automatic cfg;
    apb(1'b1, slice_instr_pkg::OFS_CTRL, cv);
    apb(1'b1, slice_instr_pkg::OFS_CUSTOM, uv);
    apb(1'b1, slice_instr_pkg::OFS_STAGE, sv);
    model(carry_in);
  endtask
  task automatic check_out;
    @(negedge pclk);
    cmp_word(32'(instr_word & em), 32'(ew & em));
    cmp_word(32'(word_width), 32'(ewd));
    cmp_word(32'(static_ctrl), 32'(es));
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    $display("watchdog expired");
    test_done();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, carry_in, load, slot, presetn} = '0;
    {cv, uv, sv, lf} = {96'h0, 32'h2E5BACDA};
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    model(1'b0);
    check_out();
    for (int i = 0; i < 12; i += 4) begin
      apb(1'b0, 8'(i), 32'h0);
      cmp_rd(rd, 32'h0);
    end
    $display("reset test done");
    for (int g = 0; g < 4; g++) begin
      for (int p = 0; p < 16; p++) begin
        lf = lfsr(lf);
        {cv, uv, sv} = {22'h0, lf[9:8], 4'(p), 2'h0, 2'(g), lf, lf >> 12};
        cfg();
        check_out();
        @(posedge pclk);
        carry_in <= ~carry_in;
        model(~carry_in);
        check_out();
      end
    end
    $display("preset and field test done");
    {cv, uv, sv} = {32'hFFFFFDF2, 32'hFFFFFFFF, 32'hFFFFFFFF};
    cfg();
    apb(1'b1, slice_instr_pkg::OFS_WORD, 32'hFFFFFFFF);
    cmp_rd(32'(err), 32'h0);
    check_out();
    apb(1'b0, slice_instr_pkg::OFS_WORD, 32'h0);
    cmp_rd(rd, 32'(ew));
    apb(1'b0, slice_instr_pkg::OFS_CTRL, 32'h0);
    cmp_rd(rd, cv & 32'h3F3);
    apb(1'b0, slice_instr_pkg::OFS_CUSTOM, 32'h0);
    cmp_rd(rd, uv & 32'h377FF);
    apb(1'b0, slice_instr_pkg::OFS_STAGE, 32'h0);
    cmp_rd(rd, sv & 32'h3FF);
    apb(1'b1, 8'h10, 32'hFFFFFFFF);
    cmp_rd(32'(err), 32'h1);
    apb(1'b0, 8'h10, 32'h0);
    cmp_rd(rd, 32'h0);
    cmp_rd(32'(err), 32'h1);
    $display("register access test done");
    for (int s = 0; s < 4; s++) begin
      {cv, uv, sv} = {24'h0, 4'(s), 4'h2, 32'h0, 32'(s)};
      cfg();
      q.push_back(ew);
      @(posedge pclk);
      {load, slot} <= {1'b1, 2'(s)};
      @(posedge pclk);
      load <= 1'b0;
    end
    for (int s = 3; s >= 0; s--) begin
      @(posedge pclk);
      slot <= 2'(s);
      @(negedge pclk);
      cmp_word(32'(step_word), 32'(q[s]));
    end
    $display("sequence test done");
    test_done();
  end
endmodule // test_slice_instr_const
`default_nettype wire
